// >>> core/lmrx_pkg.sv
package lmrx_pkg;
    // =====================================================
    // widths
    localparam int INSTR_W     = 12;
    localparam int DATA_W      = 8;
    localparam int FADDR_W     = 5;
    localparam int PC_W        = 11;
    localparam int FILE_DEPTH  = 32;
    localparam int CARRY_BIT   = 0;
    // =====================================================
    // timing: one instruction cycle is four phases of mclk
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int INSTR_CYCLE_PS  = 20000;
    localparam int PHASES_PER_CYC  = INSTR_CYCLE_PS / CLK_PERIOD_PS;
    localparam logic [1:0] PHASE_LAST = 2'(PHASES_PER_CYC - 1);
    // =====================================================
    // encodings
    localparam logic [11:0] ENC_IDLE   = 12'h000;
    localparam logic [11:0] ENC_OPTION = 12'h002;
    localparam logic [6:0]  PFX_STORE  = 7'h01;
    localparam logic [5:0]  PFX_ROTL   = 6'h0D;
    localparam logic [3:0]  PFX_RETURN_LIT = 4'h8;
    localparam logic [3:0]  PFX_LOADL  = 4'hC;
    localparam int          DEST_BIT   = 5;
    // =====================================================
    // reset values
    localparam logic [7:0]  W_RST      = 8'h00;
    localparam logic [7:0]  OPTION_RST = 8'hFF;
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [10:0] PC_RST     = 11'h000;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_OPTION,
        OP_STORE,
        OP_ROTL,
        OP_RETURN_LIT,
        OP_LOADL,
        OP_OTHER
    } lmrx_op_t;

    typedef enum logic {
        ST_RUN,
        ST_FLUSH
    } lmrx_state_t;

    function automatic lmrx_op_t lmrx_decode(input logic [11:0] iw);
        lmrx_op_t op;
        op = OP_OTHER;
        if (iw == ENC_IDLE)
            op = OP_IDLE;
        else if (iw == ENC_OPTION)
            op = OP_OPTION;
        else if (iw[11:5] == PFX_STORE)
            op = OP_STORE;
        else if (iw[11:6] == PFX_ROTL)
            op = OP_ROTL;
        else if (iw[11:8] == PFX_RETURN_LIT)
            op = OP_RETURN_LIT;
        else if (iw[11:8] == PFX_LOADL)
            op = OP_LOADL;
        return op;
    endfunction : lmrx_decode

    function automatic logic [8:0] lmrx_rotl(input logic [7:0] v, input logic c);
        return {v, c};
    endfunction : lmrx_rotl
endpackage : lmrx_pkg

// >>> core/lmrx_mem_if.sv
`timescale 1ns/10ps
interface lmrx_mem_if;
    import lmrx_pkg::*;
    logic [FADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0]  rd_data;
    logic               wr_en;
    logic [FADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0]  wr_data;

    modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
    modport mem  (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : lmrx_mem_if

// >>> core/lmrx_file_mem.sv
`timescale 1ns/10ps
module lmrx_file_mem
    import lmrx_pkg::*;
(
    input wire logic mclk,
    lmrx_mem_if.mem  bus
);
    // =====================================================
    // file registers, registered read port
    logic [DATA_W-1:0] mem_reg [FILE_DEPTH];
    logic [DATA_W-1:0] rd_data_reg;

    always_ff @(posedge mclk)
    begin
        if (bus.wr_en)
            mem_reg[bus.wr_addr] <= bus.wr_data;
    end

    // no reset on the array: contents are undefined after power-up anyway
    always_ff @(posedge mclk)
    begin
        rd_data_reg <= mem_reg[bus.rd_addr];
    end

    assign bus.rd_data = rd_data_reg;
endmodule : lmrx_file_mem

// >>> core/lmrx_exec.sv
// Contract
// - store-accumulator copies working register into the addressed file register.
// - return-with-literal loads the low eight instruction bits into working register.
// - return-with-literal pops the stack top into the program counter.
// - return-with-literal takes two instruction cycles; others here take one.
// - rotate-left shifts file value up; old carry to bit 0, bit 7 to carry.
// - the carry used by rotate-left is status bit 0.
// - rotate-left with destination 0 writes working register, file unchanged.
// - rotate-left with destination 1 writes result back to the file register.
`timescale 1ns/10ps
module lmrx_exec
    import lmrx_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic [INSTR_W-1:0]   instr_word,
    input  wire logic [PC_W-1:0]      stack_top,
    output logic                      cycle_start,
    output logic                      stack_pop,
    output logic                      flushing,
    output logic [PC_W-1:0]           pc,
    output logic [DATA_W-1:0]         w_acc,
    output logic [DATA_W-1:0]         option_val,
    output logic [DATA_W-1:0]         status_val
);
    // =====================================================
    // phase divider and instruction register
    logic [1:0]          phase_reg;
    logic [INSTR_W-1:0]  ir_reg;
    lmrx_state_t         state_reg;
    logic [PC_W-1:0]     pc_reg;
    logic [DATA_W-1:0]   w_reg;
    logic [DATA_W-1:0]   option_reg;
    logic [DATA_W-1:0]   status_reg;
    logic                cycle_start_reg;
    logic                stack_pop_reg;
    lmrx_op_t            op;
    logic                exec_en;
    logic                dest_file;
    logic [8:0]          rot;

    lmrx_mem_if mbus ();

    lmrx_file_mem u_mem (
        .mclk (mclk),
        .bus  (mbus.mem)
    );

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            phase_reg <= 2'h0;
        else if (phase_reg == PHASE_LAST)
            phase_reg <= 2'h0;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    // instruction word must be stable at phase 0 of each cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ir_reg <= ENC_IDLE;
        else if (phase_reg == 2'h0)
            ir_reg <= instr_word;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cycle_start_reg <= 1'b0;
        else
            cycle_start_reg <= (phase_reg == PHASE_LAST);
    end

    // =====================================================
    // decode and datapath
    assign op        = lmrx_decode(ir_reg);
    assign exec_en   = (phase_reg == PHASE_LAST) && (state_reg == ST_RUN);
    assign dest_file = ir_reg[DEST_BIT];
    assign rot       = lmrx_rotl(mbus.rd_data, status_reg[CARRY_BIT]);

    // read is issued through phases 1..2, so data is settled by the last phase
    assign mbus.rd_addr = ir_reg[FADDR_W-1:0];
    assign mbus.wr_addr = ir_reg[FADDR_W-1:0];

    always_comb
    begin
        mbus.wr_en   = 1'b0;
        mbus.wr_data = w_reg;
        if (exec_en && op == OP_STORE)
        begin
            mbus.wr_en   = 1'b1;
            mbus.wr_data = w_reg;
        end
        else if (exec_en && op == OP_ROTL && dest_file)
        begin
            mbus.wr_en   = 1'b1;
            mbus.wr_data = rot[7:0];
        end
    end

    // =====================================================
    // architectural state
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            w_reg <= W_RST;
        else if (exec_en)
        begin
            unique case (op)
                OP_RETURN_LIT: w_reg <= ir_reg[7:0];
                OP_LOADL: w_reg <= ir_reg[7:0];
                OP_ROTL:  if (!dest_file) w_reg <= rot[7:0];
                OP_IDLE, OP_OPTION, OP_STORE, OP_OTHER: w_reg <= w_reg;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            option_reg <= OPTION_RST;
        else if (exec_en && op == OP_OPTION)
            option_reg <= w_reg;
    end

    // only the rotate touches a flag; everything else here leaves status alone
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            status_reg <= STATUS_RST;
        else if (exec_en && op == OP_ROTL)
            status_reg[CARRY_BIT] <= rot[8];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pc_reg <= PC_RST;
        else if (exec_en && op == OP_RETURN_LIT)
            pc_reg <= stack_top;
        else if (exec_en)
            pc_reg <= pc_reg + 11'h001;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            stack_pop_reg <= 1'b0;
        else
            stack_pop_reg <= exec_en && (op == OP_RETURN_LIT);
    end

    // the word fetched behind a return is stale, so one whole cycle is discarded
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state_reg <= ST_RUN;
        else if (phase_reg == PHASE_LAST)
        begin
            unique case (state_reg)
                ST_RUN:   state_reg <= (op == OP_RETURN_LIT) ? ST_FLUSH : ST_RUN;
                ST_FLUSH: state_reg <= ST_RUN;
            endcase
        end
    end

    assign cycle_start = cycle_start_reg;
    assign stack_pop   = stack_pop_reg;
    assign flushing    = (state_reg == ST_FLUSH);
    assign pc          = pc_reg;
    assign w_acc       = w_reg;
    assign option_val  = option_reg;
    assign status_val  = status_reg;

    // =====================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_STORE_WRITE: assert property (
        exec_en && op == OP_STORE |-> mbus.wr_en && mbus.wr_data == w_reg
            && mbus.wr_addr == ir_reg[4:0])
        else $error("store did not write accumulator to file");
    AST_RETURN_W: assert property (
        exec_en && op == OP_RETURN_LIT |=> w_reg == $past(ir_reg[7:0]))
        else $error("return literal not in accumulator");
    AST_RETURN_PC: assert property (
        exec_en && op == OP_RETURN_LIT |=> pc_reg == $past(stack_top) && stack_pop_reg)
        else $error("return did not pop stack top");
    AST_RETURN_TWO: assert property (
        exec_en && op == OP_RETURN_LIT
        |=> (state_reg == ST_FLUSH)[*4] ##1 state_reg == ST_RUN)
        else $error("return did not take two cycles");
    AST_ROTL_CARRY: assert property (
        exec_en && op == OP_ROTL |=> status_reg[0] == $past(mbus.rd_data[7]))
        else $error("rotate carry out wrong");
    AST_ROTL_W: assert property (
        exec_en && op == OP_ROTL && !dest_file
        |-> !mbus.wr_en ##1 w_reg == {$past(mbus.rd_data[6:0]), $past(status_reg[0])})
        else $error("rotate to accumulator wrong");
    AST_ROTL_F: assert property (
        exec_en && op == OP_ROTL && dest_file
        |-> mbus.wr_en && mbus.wr_data == {mbus.rd_data[6:0], status_reg[0]})
        else $error("rotate to file wrong");
    AST_ROTL_CIN: assert property (
        exec_en && op == OP_ROTL |-> rot[0] == status_reg[0])
        else $error("rotate does not use status bit 0");
    AST_LOADL: assert property (
        exec_en && op == OP_LOADL |=> w_reg == $past(ir_reg[7:0]) && $stable(status_reg))
        else $error("load literal wrong");
    AST_IDLE: assert property (
        exec_en && op == OP_IDLE |=> $stable(w_reg) && $stable(option_reg)
            && pc_reg == $past(pc_reg) + 11'h001)
        else $error("idle changed state");
    AST_OPTION: assert property (
        exec_en && op == OP_OPTION |=> option_reg == $past(w_reg) && $stable(status_reg))
        else $error("option load wrong");

    COV_RETURN: cover property (exec_en && op == OP_RETURN_LIT);
    COV_ROTL_F: cover property (exec_en && op == OP_ROTL && dest_file);
    COV_ROTL_W: cover property (exec_en && op == OP_ROTL && !dest_file);
    COV_STORE:  cover property (exec_en && op == OP_STORE);
endmodule : lmrx_exec

// >>> bench/tb_lmrx_exec.sv
`timescale 1ns/10ps
module tb_lmrx_exec;
    import lmrx_pkg::*;
    // =====================================================
    // design and stimulus
    logic                 mclk;
    logic                 rst_n;
    logic [INSTR_W-1:0]   instr_word;
    logic [PC_W-1:0]      stack_top;
    logic                 cycle_start;
    logic                 stack_pop;
    logic                 flushing;
    logic [PC_W-1:0]      pc;
    logic [DATA_W-1:0]    w_acc;
    logic [DATA_W-1:0]    option_val;
    logic [DATA_W-1:0]    status_val;
    int                   fail_count;
    int                   checked;
    int                   cycles;
    logic [PC_W-1:0]      m_pc;
    logic [DATA_W-1:0]    m_w;
    logic [DATA_W-1:0]    m_opt;
    logic                 m_c;
    logic [DATA_W-1:0]    m_file [FILE_DEPTH];

    lmrx_exec u_lmrx_exec (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .instr_word  (instr_word),
        .stack_top   (stack_top),
        .cycle_start (cycle_start),
        .stack_pop   (stack_pop),
        .flushing    (flushing),
        .pc          (pc),
        .w_acc       (w_acc),
        .option_val  (option_val),
        .status_val  (status_val)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // =====================================================
    // reporting
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // the whole run is about 120 mclk; issue waits at most 16 mclk, so even a stuck phase counter ends well before this
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic check_all;
        chk("pc", 16'(pc), 16'(m_pc));
        chk("w_acc", 16'(w_acc), 16'(m_w));
        chk("option_val", 16'(option_val), 16'(m_opt));
        chk("status_val", 16'(status_val), {15'h0000, m_c});
    endtask : check_all

    // =====================================================
    // instruction driver: load while cycle_start is high, hold through execute
    task automatic issue(input logic [11:0] iw);
        int n;
        n = 0;
        while (cycle_start !== 1'b1 && n < 16)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        instr_word = iw;
        repeat (4) @(posedge mclk);
        #1;
    endtask : issue

    task automatic step(input logic [11:0] iw);
        logic [8:0] r;
        issue(iw);
        r = {m_file[iw[4:0]], m_c};
        if (iw[11:8] == 4'hC)
            m_w = iw[7:0];
        else if (iw == 12'h002)
            m_opt = m_w;
        else if (iw[11:5] == 7'h01)
            m_file[iw[4:0]] = m_w;
        else if (iw[11:6] == 6'h0D)
        begin
            if (iw[5])
                m_file[iw[4:0]] = r[7:0];
            else
                m_w = r[7:0];
            m_c = r[8];
        end
        m_pc++;
        check_all();
        chk("cycle_start", 16'(cycle_start), 16'h0001);
    endtask : step

    // =====================================================
    // scenarios
    task automatic t_store_rotate;
        step(12'hCE6);
        step(12'h021);
        step(12'h03F);
        step(12'hC00);
        step(12'h020);
        step(12'h341);
        step(12'h341);
        step(12'h37F);
        step(12'h35F);
        step(12'h360);
        step(12'h340);
    endtask : t_store_rotate

    task automatic t_literal;
        step(12'hC00);
        step(12'hCFF);
        step(12'hCA5);
        step(12'h1FF);
        step(12'h000);
        step(12'h002);
        step(12'hC3C);
        step(12'h002);
    endtask : t_literal

    task automatic t_return(input logic [10:0] ra, input logic [7:0] k);
        stack_top = ra;
        issue({4'h8, k});
        m_w = k;
        m_pc = ra;
        check_all();
        chk("stack_pop", 16'(stack_pop), 16'h0001);
        chk("flushing", 16'(flushing), 16'h0001);
        stack_top = ~ra;
        // this word lands in the flush slot and must be thrown away
        issue(12'hC11);
        check_all();
        chk("stack_pop", 16'(stack_pop), 16'h0000);
        chk("flushing", 16'(flushing), 16'h0000);
        chk("cycle_start", 16'(cycle_start), 16'h0001);
        step(12'h000);
    endtask : t_return

    initial
    begin
        rst_n = 1'b0;
        instr_word = 12'h000;
        stack_top = 11'h000;
        m_pc = 11'h000;
        m_w = 8'h00;
        m_opt = 8'hFF;
        m_c = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        check_all();
        chk("cycle_start", 16'(cycle_start), 16'h0000);
        chk("stack_pop", 16'(stack_pop), 16'h0000);
        chk("flushing", 16'(flushing), 16'h0000);
        rst_n = 1'b1;
        // the idle word sampled at the first phase executes before our first issue
        m_pc = 11'h001;
        t_store_rotate();
        t_literal();
        t_return(11'h5A3, 8'h7E);
        t_return(11'h7FF, 8'h00);
        close_out();
    end
endmodule : tb_lmrx_exec
